// ---- bench/dpsw_ctrl_properties.sv ----
// port assertions of the dual-slot power switch control block
`timescale 1ns/1ns
`include "dpsw_regs.svh"
module dpsw_ctrl_properties (
  input logic                   mclk,
  input logic                   sys_rst,
  input logic                   ser_latch,
  input logic                   card_rst,
  input logic                   card_rst_n,
  input logic [`DPSW_OUT_N-1:0] oc_sense,
  input logic                   therm_fault,
  input logic [`DPSW_SW_W-1:0]  sw_closed,
  input dpsw_pkg::dpsw_lvl_t    slot_a_supply_out,
  input dpsw_pkg::dpsw_lvl_t    slot_b_supply_out,
  input dpsw_pkg::dpsw_lvl_t    slot_a_prog_out,
  input dpsw_pkg::dpsw_lvl_t    slot_b_prog_out,
  input logic [`DPSW_OUT_N-1:0] current_limit,
  input logic                   overcurrent_flag_n
);
  // ==========================================================
  // assertions
  // pins pass two sync flops and one state flop
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_RST_HI_GND: assert property (card_rst [*4] |-> sw_closed == `DPSW_SW_GND_MASK)
    else $error("high reset pin left a power switch closed");
  AST_RST_LO_GND: assert property (!card_rst_n [*4] |-> sw_closed == `DPSW_SW_GND_MASK)
    else $error("low reset pin left a power switch closed");
  AST_FLAG_LOW: assert property ((|oc_sense) [*4] |-> !overcurrent_flag_n)
    else $error("flag high during overcurrent");
  AST_FLAG_HIGH: assert property ((oc_sense == 4'h0) [*4] |-> overcurrent_flag_n)
    else $error("flag low without overcurrent");
  AST_LIMIT_EACH: assert property ($stable(oc_sense) [*4] |-> current_limit == oc_sense)
    else $error("limit does not match its own output sense");
  AST_THERM_OFF: assert property (therm_fault [*4] |-> (sw_closed & ~`DPSW_SW_GND_MASK) == 12'h000)
    else $error("power switch closed during thermal fault");
  AST_ONE_SW: assert property ($onehot0(sw_closed[2:0]) && $onehot0(sw_closed[5:3])
    && $onehot0(sw_closed[8:6]) && $onehot0(sw_closed[11:9]))
    else $error("two switches of one output closed");
  AST_ALL_OPEN: assert property (sw_closed == 12'h000 |-> slot_a_supply_out == dpsw_pkg::DPSW_LVL_HIZ
    && slot_b_prog_out == dpsw_pkg::DPSW_LVL_HIZ)
    else $error("output driven with every switch open");
  AST_A_5V: assert property (sw_closed[2] |-> slot_a_supply_out == dpsw_pkg::DPSW_LVL_5V)
    else $error("slot a supply level wrong");
  AST_B_12V: assert property (sw_closed[11] |-> slot_b_prog_out == dpsw_pkg::DPSW_LVL_12V)
    else $error("slot b prog level wrong");
  AST_FOLLOW_A: assert property (sw_closed[7] |-> slot_a_prog_out == slot_a_supply_out)
    else $error("slot a prog does not follow supply");
  AST_FOLLOW_B: assert property (sw_closed[10] |-> slot_b_prog_out == slot_b_supply_out)
    else $error("slot b prog does not follow supply");
  AST_STEADY: assert property ((!ser_latch && !card_rst && card_rst_n && $stable(therm_fault)) [*6]
    |-> $stable(sw_closed))
    else $error("switches moved without latch, reset or thermal change");
  // ==========================================================
  // covers
  COV_LATCH: cover property ($rose(ser_latch) ##4 sw_closed != `DPSW_SW_GND_MASK);
  COV_OC: cover property (!overcurrent_flag_n);
  COV_THERM: cover property (therm_fault ##4 sw_closed != 12'h000);
endmodule // dpsw_ctrl_properties

bind dpsw_ctrl dpsw_ctrl_properties chk_u (
  .mclk(mclk), .sys_rst(sys_rst), .ser_latch(ser_latch), .card_rst(card_rst), .card_rst_n(card_rst_n),
  .oc_sense(oc_sense), .therm_fault(therm_fault), .sw_closed(sw_closed),
  .slot_a_supply_out(slot_a_supply_out), .slot_b_supply_out(slot_b_supply_out),
  .slot_a_prog_out(slot_a_prog_out), .slot_b_prog_out(slot_b_prog_out),
  .current_limit(current_limit), .overcurrent_flag_n(overcurrent_flag_n)
);

// ---- bench/dpsw_slot_ctl.sv ----
// card slot controller model driving the serial power-control link
`timescale 1ns/1ns
module dpsw_slot_ctl (
  output logic ser_data,
  output logic ser_clk,
  output logic ser_latch
);
  initial begin
    ser_data = 1'b0;
    ser_clk = 1'b0;
    ser_latch = 1'b0;
  end
  // clock idles low between frames; data turns over once hold ends
  task automatic send(input logic [8:0] w, input logic do_latch);
    for (int k = 8; k >= 0; k--) begin
      ser_data = w[k];
      #120 ser_clk = 1'b1;
      #120 ser_data = ~w[k];
      #80 ser_clk = 1'b0;
    end
    if (do_latch) begin
      // latch before any further clock rise
      #80 ser_latch = 1'b1;
      #160 ser_latch = 1'b0;
    end
    #160;
  endtask
endmodule // dpsw_slot_ctl

// ---- bench/tb_dual_slot_power_switch_control.sv ----
// self-checking bench of the dual-slot power switch control block
`timescale 1ns/1ns
`include "dpsw_regs.svh"
module tb_dual_slot_power_switch_control;
  logic                mclk;
  logic                sys_rst;
  logic                ser_data;
  logic                ser_clk;
  logic                ser_latch;
  logic                card_rst;
  logic                card_rst_n;
  logic [3:0]          oc_sense;
  logic                therm_fault;
  logic [11:0]         sw_closed;
  dpsw_pkg::dpsw_lvl_t a_sup;
  dpsw_pkg::dpsw_lvl_t b_sup;
  dpsw_pkg::dpsw_lvl_t a_prog;
  dpsw_pkg::dpsw_lvl_t b_prog;
  logic [3:0]          current_limit;
  logic                overcurrent_flag_n;
  logic [7:0]          reg_addr;
  logic [31:0]         reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [31:0]         reg_rdata;
  logic                irq;
  int                  err_total;
  int                  compares;

  dpsw_ctrl dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .ser_data(ser_data), .ser_clk(ser_clk), .ser_latch(ser_latch),
    .card_rst(card_rst), .card_rst_n(card_rst_n), .oc_sense(oc_sense), .therm_fault(therm_fault),
    .sw_closed(sw_closed), .slot_a_supply_out(a_sup), .slot_b_supply_out(b_sup),
    .slot_a_prog_out(a_prog), .slot_b_prog_out(b_prog), .current_limit(current_limit),
    .overcurrent_flag_n(overcurrent_flag_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
  );
  dpsw_slot_ctl ctl_u (.ser_data(ser_data), .ser_clk(ser_clk), .ser_latch(ser_latch));

  // ==========================================================
  // expectations
  function automatic logic [11:0] exp_sw(input logic [8:0] w);
    logic [11:0] s;
    s = 12'h000;
    if (w[8]) begin
      s[0] = w[3] == w[2];
      s[1] = w[2] & ~w[3];
      s[2] = w[3] & ~w[2];
      s[3] = w[6] == w[7];
      s[4] = w[7] & ~w[6];
      s[5] = w[6] & ~w[7];
      s[6] = w[1:0] == 2'b00;
      s[7] = w[1:0] == 2'b10;
      s[8] = w[1:0] == 2'b01;
      s[9] = w[5:4] == 2'b00;
      s[10] = w[5:4] == 2'b10;
      s[11] = w[5:4] == 2'b01;
    end
    return s;
  endfunction
  function automatic dpsw_pkg::dpsw_lvl_t sup_lvl(input logic [2:0] s);
    return s[0] ? dpsw_pkg::DPSW_LVL_GND : s[1] ? dpsw_pkg::DPSW_LVL_3V3 :
           s[2] ? dpsw_pkg::DPSW_LVL_5V : dpsw_pkg::DPSW_LVL_HIZ;
  endfunction
  function automatic dpsw_pkg::dpsw_lvl_t prog_lvl(input logic [2:0] s, input dpsw_pkg::dpsw_lvl_t sup);
    return s[0] ? dpsw_pkg::DPSW_LVL_GND : s[1] ? sup : s[2] ? dpsw_pkg::DPSW_LVL_12V : dpsw_pkg::DPSW_LVL_HIZ;
  endfunction

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  task automatic link_send(input logic [8:0] w, input logic l);
    ctl_u.send(w, l);
    idle(6);
  endtask
  task automatic chk_dec(input logic [8:0] w);
    logic [11:0] s;
    s = exp_sw(w);
    chk(32'(sw_closed), 32'(s));
    chk(32'(a_sup), 32'(sup_lvl(s[2:0])));
    chk(32'(b_sup), 32'(sup_lvl(s[5:3])));
    chk(32'(a_prog), 32'(prog_lvl(s[8:6], sup_lvl(s[2:0]))));
    chk(32'(b_prog), 32'(prog_lvl(s[11:9], sup_lvl(s[5:3]))));
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] d;
    chk(32'(sw_closed), 32'(`DPSW_SW_GND_MASK));
    rd(`DPSW_ADDR_MASK, d);
    chk(d, 32'h0000_0000);
    wr(`DPSW_ADDR_MASK, 32'h0000_001f);
    rd(`DPSW_ADDR_MASK, d);
    chk(d, 32'h0000_001f);
    wr(`DPSW_ADDR_MASK, 32'h0000_0001);
    wr(`DPSW_ADDR_STATUS, 32'h0000_001f);
    link_send(9'h1aa, 1'b1);
    chk(32'(irq), 32'h1);
    wr(`DPSW_ADDR_MASK, 32'h0000_0000);
    idle(2);
    chk(32'(irq), 32'h0);
    wr(`DPSW_ADDR_MASK, 32'h0000_0001);
    idle(2);
    chk(32'(irq), 32'h1);
    wr(`DPSW_ADDR_STATUS, 32'h0000_0001);
    idle(2);
    chk(32'(irq), 32'h0);
    wr(8'h18, 32'hffff_ffff);
    rd(8'h18, d);
    chk(d, 32'h0000_0000);
    wr(`DPSW_ADDR_WORD, 32'h0000_0000);
    rd(`DPSW_ADDR_WORD, d);
    chk(d, 32'h0000_01aa);
    $display("test registers done");
  endtask
  task automatic t_decode();
    logic [8:0]  w [7] = '{9'h100, 9'h155, 9'h1aa, 9'h1ff, 9'h0ff, 9'h102, 9'h120};
    logic [31:0] d;
    foreach (w[i]) begin
      link_send(w[i], 1'b1);
      chk_dec(w[i]);
      rd(`DPSW_ADDR_WORD, d);
      chk(d, {23'h0, w[i]});
    end
    $display("test decode done");
  endtask
  task automatic t_hold();
    link_send(9'h155, 1'b1);
    link_send(9'h1aa, 1'b0);
    chk_dec(9'h155);
    link_send(9'h1aa, 1'b1);
    chk_dec(9'h1aa);
    $display("test hold done");
  endtask
  task automatic t_pinrst();
    for (int k = 0; k < 2; k++) begin
      link_send(9'h1aa, 1'b1);
      @(posedge mclk);
      if (k == 0) card_rst <= 1'b1;
      else card_rst_n <= 1'b0;
      idle(6);
      chk(32'(sw_closed), 32'(`DPSW_SW_GND_MASK));
      link_send(9'h155, 1'b1);
      chk(32'(sw_closed), 32'(`DPSW_SW_GND_MASK));
      @(posedge mclk);
      card_rst <= 1'b0;
      card_rst_n <= 1'b1;
      idle(6);
      chk(32'(sw_closed), 32'(`DPSW_SW_GND_MASK));
      link_send(9'h155, 1'b1);
      chk_dec(9'h155);
    end
    $display("test pin reset done");
  endtask
  task automatic t_oc();
    link_send(9'h1aa, 1'b1);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      oc_sense <= 4'h1 << i;
      idle(6);
      chk(32'(current_limit), 32'h1 << i);
      chk(32'(overcurrent_flag_n), 32'h0);
      chk_dec(9'h1aa);
    end
    @(posedge mclk);
    oc_sense <= 4'h0;
    idle(6);
    chk(32'(overcurrent_flag_n), 32'h1);
    $display("test overcurrent done");
  endtask
  task automatic t_therm();
    link_send(9'h155, 1'b1);
    @(posedge mclk);
    therm_fault <= 1'b1;
    idle(6);
    chk(32'(sw_closed), 32'(exp_sw(9'h155) & `DPSW_SW_GND_MASK));
    link_send(9'h1aa, 1'b1);
    chk(32'(sw_closed), 32'(exp_sw(9'h1aa) & `DPSW_SW_GND_MASK));
    @(posedge mclk);
    therm_fault <= 1'b0;
    idle(6);
    chk_dec(9'h1aa);
    $display("test thermal done");
  endtask

  task automatic conclude();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // clock, sequence, watchdog
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    sys_rst = 1'b1;
    card_rst = 1'b0;
    card_rst_n = 1'b1;
    oc_sense = 4'h0;
    therm_fault = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    idle(2);
    t_regs();
    t_decode();
    t_hold();
    t_pinrst();
    t_oc();
    t_therm();
    conclude();
  end
  // about 20 frames of some 3.5 us each; wide margin
  initial begin
    #400000;
    err_total++;
    conclude();
  end
endmodule // tb_dual_slot_power_switch_control

// ---- rtl/dpsw_ctrl.sv ----
// dual-slot power switch control: serial word, switch decode, faults, registers
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "dpsw_regs.svh"
module dpsw_ctrl #(
  parameter int AW = 8,
  parameter int DW = 32
) (
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  // serial control link
  input  wire logic                    ser_data,
  input  wire logic                    ser_clk,
  input  wire logic                    ser_latch,
  // reset pins
  input  wire logic                    card_rst,
  input  wire logic                    card_rst_n,
  // analog fault sense
  input  wire logic [`DPSW_OUT_N-1:0]  oc_sense,
  input  wire logic                    therm_fault,
  // switch drive and output levels
  output logic      [`DPSW_SW_W-1:0]   sw_closed,
  output dpsw_pkg::dpsw_lvl_t          slot_a_supply_out,
  output dpsw_pkg::dpsw_lvl_t          slot_b_supply_out,
  output dpsw_pkg::dpsw_lvl_t          slot_a_prog_out,
  output dpsw_pkg::dpsw_lvl_t          slot_b_prog_out,
  output logic      [`DPSW_OUT_N-1:0]  current_limit,
  output logic                         overcurrent_flag_n,
  // register port
  input  wire logic [AW-1:0]           reg_addr,
  input  wire logic [DW-1:0]           reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [DW-1:0]           reg_rdata,
  output logic                         irq
);

  // ==========================================================
  // state
  localparam dpsw_pkg::dpsw_state_t ST_RST = '{
    shift:      `DPSW_WORD_RST,
    word:       `DPSW_WORD_RST,
    grounded:   1'b1,
    sclk_prev:  1'b0,
    latch_prev: 1'b0,
    therm_prev: 1'b0,
    prst_prev:  1'b0,
    oc_prev:    '0,
    sw:         `DPSW_SW_GND_MASK,
    a_sup:      dpsw_pkg::DPSW_LVL_GND,
    b_sup:      dpsw_pkg::DPSW_LVL_GND,
    a_prog:     dpsw_pkg::DPSW_LVL_GND,
    b_prog:     dpsw_pkg::DPSW_LVL_GND,
    limit:      '0,
    flag_n:     1'b1,
    status:     `DPSW_EV_RST,
    mask:       `DPSW_EV_RST,
    rdata:      '0
  };

  dpsw_pkg::dpsw_state_t st_r;
  dpsw_pkg::dpsw_state_t st_nxt;

  // ==========================================================
  // pin synchronisers
  logic [`DPSW_SYNC_W-1:0] pins_raw;
  logic [`DPSW_SYNC_W-1:0] pins_s;

  assign pins_raw = {oc_sense, therm_fault, card_rst_n, card_rst, ser_latch, ser_data, ser_clk};

  // the link clock is only sampled; data and clock share equal latency
  dpsw_sync #(
    .W    (`DPSW_SYNC_W),
    .INIT (`DPSW_SYNC_INIT)
  ) u_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .pin_in   (pins_raw),
    .pin_sync (pins_s)
  );

  logic                   sclk_s;
  logic                   sdata_s;
  logic                   latch_s;
  logic                   therm_s;
  logic                   pin_rst;
  logic [`DPSW_OUT_N-1:0] oc_s;

  assign sclk_s  = pins_s[`DPSW_SY_SCLK];
  assign sdata_s = pins_s[`DPSW_SY_SDATA];
  assign latch_s = pins_s[`DPSW_SY_LATCH];
  assign therm_s = pins_s[`DPSW_SY_THERM];
  assign oc_s    = pins_s[`DPSW_SY_OC +: `DPSW_OUT_N];
  assign pin_rst = pins_s[`DPSW_SY_RST_HI] | ~pins_s[`DPSW_SY_RST_N];

  // ==========================================================
  // decode functions

  // supply triple {sel_b, sel_a, gnd}: first/second are the pair bits as written
  function automatic logic [2:0] dec_supply(input logic first, input logic second);
    logic [2:0] t;
    t = 3'h1;
    case ({first, second})
      2'b01:   t = 3'h2;
      2'b10:   t = 3'h4;
      default: t = 3'h1;
    endcase
    return t;
  endfunction

  // programming triple {high, follow, gnd}; 11 leaves all open
  function automatic logic [2:0] dec_prog(input logic first, input logic second);
    logic [2:0] t;
    t = 3'h0;
    case ({first, second})
      2'b00:   t = 3'h1;
      2'b01:   t = 3'h2;
      2'b10:   t = 3'h4;
      default: t = 3'h0;
    endcase
    return t;
  endfunction

  function automatic dpsw_pkg::dpsw_lvl_t lvl_supply(input logic [2:0] t);
    dpsw_pkg::dpsw_lvl_t l;
    l = dpsw_pkg::DPSW_LVL_HIZ;
    if (t[0]) begin
      l = dpsw_pkg::DPSW_LVL_GND;
    end else if (t[1]) begin
      l = dpsw_pkg::DPSW_LVL_3V3;
    end else if (t[2]) begin
      l = dpsw_pkg::DPSW_LVL_5V;
    end
    return l;
  endfunction

  function automatic dpsw_pkg::dpsw_lvl_t lvl_prog(input logic [2:0] t, input dpsw_pkg::dpsw_lvl_t sup);
    dpsw_pkg::dpsw_lvl_t l;
    l = dpsw_pkg::DPSW_LVL_HIZ;
    if (t[0]) begin
      l = dpsw_pkg::DPSW_LVL_GND;
    end else if (t[1]) begin
      l = sup;
    end else if (t[2]) begin
      l = dpsw_pkg::DPSW_LVL_12V;
    end
    return l;
  endfunction

  function automatic logic [DW-1:0] reg_read(input logic [AW-1:0] a, input dpsw_pkg::dpsw_state_t s,
                                             input logic [`DPSW_SYNC_W-1:0] p);
    logic [DW-1:0] v;
    v = '0;
    case (a)
      `DPSW_ADDR_WORD:   v[`DPSW_WORD_W:0] = {s.grounded, s.word};
      `DPSW_ADDR_SHIFT:  v[`DPSW_WORD_W-1:0] = s.shift;
      `DPSW_ADDR_SWITCH: v[`DPSW_SW_W-1:0] = s.sw;
      `DPSW_ADDR_FAULT:  v[`DPSW_OUT_N+1:0] = {s.grounded, p[`DPSW_SY_THERM], p[`DPSW_SY_OC +: `DPSW_OUT_N]};
      `DPSW_ADDR_STATUS: v[`DPSW_EV_W-1:0] = s.status;
      `DPSW_ADDR_MASK:   v[`DPSW_EV_W-1:0] = s.mask;
      default:           v = '0;
    endcase
    return v;
  endfunction

  // ==========================================================
  // next state
  logic                   sclk_rise;
  logic                   latch_rise;
  logic [`DPSW_SW_W-1:0]  sw_dec;
  logic [`DPSW_SW_W-1:0]  sw_sel;
  logic [`DPSW_EV_W-1:0]  ev;
  logic [`DPSW_EV_W-1:0]  w1c;
  dpsw_pkg::dpsw_lvl_t    a_sup_l;
  dpsw_pkg::dpsw_lvl_t    b_sup_l;

  assign sclk_rise  = sclk_s & ~st_r.sclk_prev;
  assign latch_rise = latch_s & ~st_r.latch_prev;

  always_comb begin
    st_nxt            = st_r;
    st_nxt.sclk_prev  = sclk_s;
    st_nxt.latch_prev = latch_s;
    st_nxt.therm_prev = therm_s;
    st_nxt.prst_prev  = pin_rst;
    st_nxt.oc_prev    = oc_s;

    // d8 enters first and ends at the top
    if (sclk_rise) begin
      st_nxt.shift = {st_r.shift[`DPSW_WORD_W-2:0], sdata_s};
    end

    // reset holds grounding until a fresh latch
    if (pin_rst) begin
      st_nxt.grounded = 1'b1;
    end else if (latch_rise) begin
      st_nxt.word     = st_r.shift;
      st_nxt.grounded = 1'b0;
    end

    sw_dec = `DPSW_SW_OPEN;
    if (st_r.word[`DPSW_OUTPUTS_ENABLE_BIT]) begin
      sw_dec[`DPSW_SW_A_SUP +: 3]  = dec_supply(st_r.word[`DPSW_A_SUPPLY_SEL_HI],
                                                st_r.word[`DPSW_A_SUPPLY_SEL_LO]);
      sw_dec[`DPSW_SW_B_SUP +: 3]  = dec_supply(st_r.word[`DPSW_B_SUPPLY_SEL_LO],
                                                st_r.word[`DPSW_B_SUPPLY_SEL_HI]);
      sw_dec[`DPSW_SW_A_PROG +: 3] = dec_prog(st_r.word[`DPSW_A_PROG_HIGH_SEL],
                                              st_r.word[`DPSW_A_PROG_FOLLOW_SEL]);
      sw_dec[`DPSW_SW_B_PROG +: 3] = dec_prog(st_r.word[`DPSW_B_PROG_HIGH_SEL],
                                              st_r.word[`DPSW_B_PROG_FOLLOW_SEL]);
    end

    if (pin_rst || st_r.grounded) begin
      sw_sel = `DPSW_SW_GND_MASK;
    end else if (therm_s) begin
      sw_sel = sw_dec & `DPSW_SW_GND_MASK;
    end else begin
      sw_sel = sw_dec;
    end
    st_nxt.sw = sw_sel;

    a_sup_l       = lvl_supply(sw_sel[`DPSW_SW_A_SUP +: 3]);
    b_sup_l       = lvl_supply(sw_sel[`DPSW_SW_B_SUP +: 3]);
    st_nxt.a_sup  = a_sup_l;
    st_nxt.b_sup  = b_sup_l;
    st_nxt.a_prog = lvl_prog(sw_sel[`DPSW_SW_A_PROG +: 3], a_sup_l);
    st_nxt.b_prog = lvl_prog(sw_sel[`DPSW_SW_B_PROG +: 3], b_sup_l);

    st_nxt.limit  = oc_s;
    st_nxt.flag_n = ~(|oc_s);

    // ----------------------------------------------------------
    // events; a set in the clearing cycle survives
    ev                        = `DPSW_EV_RST;
    ev[`DPSW_EV_LATCHED]      = latch_rise & ~pin_rst;
    ev[`DPSW_EV_OVERCURRENT]  = |(oc_s & ~st_r.oc_prev);
    ev[`DPSW_EV_THERM_SET]    = therm_s & ~st_r.therm_prev;
    ev[`DPSW_EV_THERM_CLR]    = ~therm_s & st_r.therm_prev;
    ev[`DPSW_EV_PIN_RESET]    = pin_rst & ~st_r.prst_prev;

    w1c = `DPSW_EV_RST;
    if (reg_wr && reg_addr == `DPSW_ADDR_STATUS) begin
      w1c = reg_wdata[`DPSW_EV_W-1:0];
    end
    st_nxt.status = (st_r.status & ~w1c) | ev;

    if (reg_wr && reg_addr == `DPSW_ADDR_MASK) begin
      st_nxt.mask = reg_wdata[`DPSW_EV_W-1:0];
    end

    // read data valid only in the cycle after the strobe
    st_nxt.rdata = '0;
    if (reg_rd) begin
      st_nxt.rdata = reg_read(reg_addr, st_r, pins_s);
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign sw_closed          = st_r.sw;
  assign slot_a_supply_out  = st_r.a_sup;
  assign slot_b_supply_out  = st_r.b_sup;
  assign slot_a_prog_out    = st_r.a_prog;
  assign slot_b_prog_out    = st_r.b_prog;
  assign current_limit      = st_r.limit;
  assign overcurrent_flag_n = st_r.flag_n;
  assign reg_rdata          = st_r.rdata;
  // level interrupt, combinational from flops
  assign irq                = |(st_r.status & st_r.mask);

endmodule // dpsw_ctrl

// ---- rtl/dpsw_pkg.sv ----
// types of the dual-slot power switch control block
`include "dpsw_regs.svh"
package dpsw_pkg;

  // level delivered on one output
  typedef enum logic [2:0] {
    DPSW_LVL_HIZ,
    DPSW_LVL_GND,
    DPSW_LVL_3V3,
    DPSW_LVL_5V,
    DPSW_LVL_12V
  } dpsw_lvl_t;

  typedef struct packed {
    logic [`DPSW_WORD_W-1:0] shift;
    logic [`DPSW_WORD_W-1:0] word;
    logic                    grounded;
    logic                    sclk_prev;
    logic                    latch_prev;
    logic                    therm_prev;
    logic                    prst_prev;
    logic [`DPSW_OUT_N-1:0]  oc_prev;
    logic [`DPSW_SW_W-1:0]   sw;
    dpsw_lvl_t               a_sup;
    dpsw_lvl_t               b_sup;
    dpsw_lvl_t               a_prog;
    dpsw_lvl_t               b_prog;
    logic [`DPSW_OUT_N-1:0]  limit;
    logic                    flag_n;
    logic [`DPSW_EV_W-1:0]   status;
    logic [`DPSW_EV_W-1:0]   mask;
    logic [31:0]             rdata;
  } dpsw_state_t;

endpackage

// ---- rtl/dpsw_regs.svh ----
// constants of the dual-slot power switch control block
`ifndef DPSW_REGS_SVH
`define DPSW_REGS_SVH

// ==========================================================
// control word layout
`define DPSW_WORD_W             9
`define DPSW_A_PROG_HIGH_SEL    0
`define DPSW_A_PROG_FOLLOW_SEL  1
`define DPSW_A_SUPPLY_SEL_LO    2
`define DPSW_A_SUPPLY_SEL_HI    3
`define DPSW_B_PROG_HIGH_SEL    4
`define DPSW_B_PROG_FOLLOW_SEL  5
`define DPSW_B_SUPPLY_SEL_LO    6
`define DPSW_B_SUPPLY_SEL_HI    7
`define DPSW_OUTPUTS_ENABLE_BIT 8
`define DPSW_WORD_RST           9'h000

// ==========================================================
// switch vector: bit n is switch S(n+1), three per output
`define DPSW_SW_W               12
`define DPSW_SW_A_SUP           0
`define DPSW_SW_B_SUP           3
`define DPSW_SW_A_PROG          6
`define DPSW_SW_B_PROG          9
`define DPSW_SW_GND_MASK        12'h249
`define DPSW_SW_OPEN            12'h000

// ==========================================================
// output index of overcurrent and limit vectors
`define DPSW_OUT_N              4
`define DPSW_OUT_A_SUP          0
`define DPSW_OUT_B_SUP          1
`define DPSW_OUT_A_PROG         2
`define DPSW_OUT_B_PROG         3

// ==========================================================
// register offsets
`define DPSW_ADDR_WORD          8'h00
`define DPSW_ADDR_SHIFT         8'h04
`define DPSW_ADDR_SWITCH        8'h08
`define DPSW_ADDR_FAULT         8'h0c
`define DPSW_ADDR_STATUS        8'h10
`define DPSW_ADDR_MASK          8'h14

// ==========================================================
// event bits of status and mask
`define DPSW_EV_W               5
`define DPSW_EV_LATCHED         0
`define DPSW_EV_OVERCURRENT     1
`define DPSW_EV_THERM_SET       2
`define DPSW_EV_THERM_CLR       3
`define DPSW_EV_PIN_RESET       4
`define DPSW_EV_RST             5'h00

// ==========================================================
// synchroniser lane layout and reset levels
`define DPSW_SYNC_W             10
`define DPSW_SY_SCLK            0
`define DPSW_SY_SDATA           1
`define DPSW_SY_LATCH           2
`define DPSW_SY_RST_HI          3
`define DPSW_SY_RST_N           4
`define DPSW_SY_THERM           5
`define DPSW_SY_OC              6
`define DPSW_SYNC_INIT          10'h010

`endif

// ---- rtl/dpsw_sync.sv ----
// two-flop synchroniser for pins from outside the mclk domain
`timescale 1ns/1ns
module dpsw_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dpsw_sync_t;

  dpsw_sync_t st_r;
  dpsw_sync_t st_nxt;

  // first stage feeds only the second stage
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '{s1: INIT, s2: INIT};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_sync = st_r.s2;

endmodule // dpsw_sync
